// >>> lssre_consts.svh
// constants for the literal-subtract / power-down / rotate execution block
// assumes a 14-bit instruction word and an 8-bit data path
`ifndef LSSRE_CONSTS_SVH
`define LSSRE_CONSTS_SVH

// opcode masks and match values
`define LSSRE_SUBL_MASK   14'h3E00
`define LSSRE_SUBL_MATCH  14'h3C00
`define LSSRE_SLEEP_CODE  14'h0063
`define LSSRE_ROT_MASK    14'h3F00
`define LSSRE_ROTL_MATCH  14'h0D00
`define LSSRE_ROTR_MATCH  14'h0C00
`define LSSRE_DEST_BIT    7

// software register offsets (index on regAddr)
`define LSSRE_OFF_STATUS  2'h0
`define LSSRE_OFF_ACC     2'h1
`define LSSRE_OFF_WDTVAL  2'h2

// status register bit positions
`define LSSRE_ST_CARRY    0
`define LSSRE_ST_HALF     1
`define LSSRE_ST_ZERO     2
`define LSSRE_ST_PDN      3
`define LSSRE_ST_TON      4
`define LSSRE_ST_ASLEEP   5

// reset and load values
`define LSSRE_ACC_RST     8'h00
`define LSSRE_WDT_CLRVAL  8'h00
`define LSSRE_INSTR_RST   14'h0000

`endif

// >>> lssre_pkg.sv
// types shared by the execution block and its surroundings
// assumes nothing beyond the constants header
`default_nettype none
package lssre_pkg;

   typedef enum logic [1:0] {
      LSSRE_Q1,
      LSSRE_Q2,
      LSSRE_Q3,
      LSSRE_Q4
   } lssre_qphase_t;

   typedef enum logic [2:0] {
      LSSRE_OP_NONE,
      LSSRE_OP_SUBL,
      LSSRE_OP_SLEEP,
      LSSRE_OP_ROTL,
      LSSRE_OP_ROTR
   } lssre_op_t;

   typedef struct packed {
      logic timeoutFlagN;
      logic powerDownFlagN;
      logic zero;
      logic halfBorrowFlag;
      logic carry;
   } lssre_status_t;

   typedef struct packed {
      logic [6:0] addr;
      logic [7:0] data;
      logic       wrEn;
   } lssre_filewr_t;

endpackage
`default_nettype wire

// >>> lssre_exec.sv
// execution of literal-minus-accumulator, power-down and rotates
// assumes instr stable at the Q1 edge, fileRdData valid at the Q2 edge,
// and the core's watchdog honouring the clear pulse
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "lssre_consts.svh"

module lssre_exec
   import lssre_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          nrst,
   input  wire logic [13:0]   instr,
   input  wire logic [7:0]    fileRdData,
   input  wire logic          wakeRaw,
   input  wire logic [1:0]    regAddr,
   input  wire logic [7:0]    regWrData,
   input  wire logic          regWr,
   input  wire logic          regRd,
   output var  logic [7:0]    regRdData,
   output var  lssre_filewr_t fileWr,
   output var  lssre_status_t status,
   output var  logic [7:0]    accumulator,
   output var  logic          wdtClear,
   output var  logic [7:0]    wdtLoadValue,
   output var  logic          oscRun,
   output var  lssre_qphase_t qPhase
);

   function automatic lssre_op_t decode_op(input logic [13:0] w);
      lssre_op_t o;
      o = LSSRE_OP_NONE;
      if ((w & `LSSRE_SUBL_MASK) == `LSSRE_SUBL_MATCH)
         o = LSSRE_OP_SUBL;
      else if (w == `LSSRE_SLEEP_CODE)
         o = LSSRE_OP_SLEEP;
      else if ((w & `LSSRE_ROT_MASK) == `LSSRE_ROTL_MATCH)
         o = LSSRE_OP_ROTL;
      else if ((w & `LSSRE_ROT_MASK) == `LSSRE_ROTR_MATCH)
         o = LSSRE_OP_ROTR;
      return o;
   endfunction

   lssre_qphase_t q_r, q_nxt;
   lssre_status_t st_r, st_nxt;
   logic [13:0]   instr_r, instr_nxt;
   logic [7:0]    operand_r, operand_nxt;
   logic [7:0]    acc_r, acc_nxt;
   logic [7:0]    fileData_r, fileData_nxt;
   logic          fileWrEn_r, fileWrEn_nxt;
   logic          wdtClear_r, wdtClear_nxt;
   logic [7:0]    wdtVal_r, wdtVal_nxt;
   logic          sleep_r, sleep_nxt;
   logic [7:0]    rdData_r, rdData_nxt;
   logic          wakeMeta_r, wakeSync_r;
   lssre_op_t     opCur;
   logic [8:0]    diff;
   logic [4:0]    nibDiff;
   logic [7:0]    rotLeft;
   logic [7:0]    rotRight;
   logic          destFile;

   assign opCur    = decode_op(instr_r);
   // 9-bit difference: bit 8 is the borrow
   assign diff     = {1'b0, instr_r[7:0]} - {1'b0, acc_r};
   assign nibDiff  = {1'b0, instr_r[3:0]} - {1'b0, acc_r[3:0]};
   assign rotLeft  = {operand_r[6:0], st_r.carry};
   assign rotRight = {st_r.carry, operand_r[7:1]};
   assign destFile = instr_r[`LSSRE_DEST_BIT];

   always_comb begin
      q_nxt        = q_r;
      st_nxt       = st_r;
      instr_nxt    = instr_r;
      operand_nxt  = operand_r;
      acc_nxt      = acc_r;
      fileData_nxt = fileData_r;
      fileWrEn_nxt = 1'b0;
      wdtClear_nxt = 1'b0;
      wdtVal_nxt   = wdtVal_r;
      sleep_nxt    = sleep_r;
      // software writes first; a Q4 result in the same cycle overrides
      if (regWr) begin
         unique case (regAddr)
            `LSSRE_OFF_STATUS: begin
               st_nxt.carry          = regWrData[`LSSRE_ST_CARRY];
               st_nxt.halfBorrowFlag = regWrData[`LSSRE_ST_HALF];
               st_nxt.zero           = regWrData[`LSSRE_ST_ZERO];
            end
            `LSSRE_OFF_ACC: acc_nxt = regWrData;
            default: ;
         endcase
      end
      if (sleep_r) begin
         if (wakeSync_r) begin
            sleep_nxt = 1'b0;
            q_nxt     = LSSRE_Q1;
         end
      end else begin
         unique case (q_r)
            LSSRE_Q1: begin
               instr_nxt = instr;
               q_nxt     = LSSRE_Q2;
            end
            LSSRE_Q2: begin
               operand_nxt = fileRdData;
               q_nxt       = LSSRE_Q3;
            end
            LSSRE_Q3: q_nxt = LSSRE_Q4;
            LSSRE_Q4: begin
               q_nxt = LSSRE_Q1;
               unique case (opCur)
                  LSSRE_OP_SUBL: begin
                     acc_nxt               = diff[7:0];
                     st_nxt.carry          = ~diff[8];
                     st_nxt.halfBorrowFlag = ~nibDiff[4];
                     st_nxt.zero           = (diff[7:0] == 8'h00);
                  end
                  LSSRE_OP_SLEEP: begin
                     st_nxt.powerDownFlagN = 1'b0;
                     st_nxt.timeoutFlagN   = 1'b1;
                     wdtClear_nxt          = 1'b1;
                     wdtVal_nxt            = `LSSRE_WDT_CLRVAL;
                     sleep_nxt             = 1'b1;
                  end
                  LSSRE_OP_ROTL: begin
                     st_nxt.carry = operand_r[7];
                     if (destFile) begin
                        fileData_nxt = rotLeft;
                        fileWrEn_nxt = 1'b1;
                     end else begin
                        acc_nxt = rotLeft;
                     end
                  end
                  LSSRE_OP_ROTR: begin
                     st_nxt.carry = operand_r[0];
                     if (destFile) begin
                        fileData_nxt = rotRight;
                        fileWrEn_nxt = 1'b1;
                     end else begin
                        acc_nxt = rotRight;
                     end
                  end
                  default: ;
               endcase
            end
         endcase
      end
   end

   always_comb begin
      rdData_nxt = 8'h00;
      if (regRd) begin
         unique case (regAddr)
            `LSSRE_OFF_STATUS: begin
               rdData_nxt[`LSSRE_ST_CARRY]  = st_r.carry;
               rdData_nxt[`LSSRE_ST_HALF]   = st_r.halfBorrowFlag;
               rdData_nxt[`LSSRE_ST_ZERO]   = st_r.zero;
               rdData_nxt[`LSSRE_ST_PDN]    = st_r.powerDownFlagN;
               rdData_nxt[`LSSRE_ST_TON]    = st_r.timeoutFlagN;
               rdData_nxt[`LSSRE_ST_ASLEEP] = sleep_r;
            end
            `LSSRE_OFF_ACC:    rdData_nxt = acc_r;
            `LSSRE_OFF_WDTVAL: rdData_nxt = wdtVal_r;
            default:           rdData_nxt = 8'h00;
         endcase
      end
   end

   // wake pin synchroniser
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wakeMeta_r <= 1'b0;
         wakeSync_r <= 1'b0;
      end else begin
         wakeMeta_r <= wakeRaw;
         wakeSync_r <= wakeMeta_r;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         q_r        <= LSSRE_Q1;
         st_r       <= '{timeoutFlagN: 1'b1, powerDownFlagN: 1'b1,
                         zero: 1'b0, halfBorrowFlag: 1'b0, carry: 1'b0};
         instr_r    <= `LSSRE_INSTR_RST;
         operand_r  <= 8'h00;
         acc_r      <= `LSSRE_ACC_RST;
         fileData_r <= 8'h00;
         fileWrEn_r <= 1'b0;
         wdtClear_r <= 1'b0;
         wdtVal_r   <= `LSSRE_WDT_CLRVAL;
         sleep_r    <= 1'b0;
         rdData_r   <= 8'h00;
      end else begin
         q_r        <= q_nxt;
         st_r       <= st_nxt;
         instr_r    <= instr_nxt;
         operand_r  <= operand_nxt;
         acc_r      <= acc_nxt;
         fileData_r <= fileData_nxt;
         fileWrEn_r <= fileWrEn_nxt;
         wdtClear_r <= wdtClear_nxt;
         wdtVal_r   <= wdtVal_nxt;
         sleep_r    <= sleep_nxt;
         rdData_r   <= rdData_nxt;
      end
   end

   assign regRdData    = rdData_r;
   assign fileWr       = '{addr: instr_r[6:0], data: fileData_r,
                           wrEn: fileWrEn_r};
   assign status       = st_r;
   assign accumulator  = acc_r;
   assign wdtClear     = wdtClear_r;
   assign wdtLoadValue = wdtVal_r;
   assign oscRun       = ~sleep_r;
   assign qPhase       = q_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence subl_exec_s;
      !sleep_r && q_r == LSSRE_Q4 && opCur == LSSRE_OP_SUBL;
   endsequence

   sequence sleep_exec_s;
      !sleep_r && q_r == LSSRE_Q4 && opCur == LSSRE_OP_SLEEP;
   endsequence

   subl_result_a: assert property (subl_exec_s |=>
      acc_r == $past(diff[7:0]) && !fileWrEn_r)
      else $error("literal minus W result wrong");
   subl_carry_a: assert property (subl_exec_s |=>
      st_r.carry == ($past(instr_r[7:0]) >= $past(acc_r)))
      else $error("borrow flag wrong after subtract");
   subl_zero_a: assert property (subl_exec_s |=>
      st_r.zero == (acc_r == 8'h00) &&
      st_r.halfBorrowFlag == ($past(instr_r[3:0]) >= $past(acc_r[3:0])))
      else $error("zero or half borrow wrong after subtract");
   sleep_flags_a: assert property (sleep_exec_s |=>
      !st_r.powerDownFlagN && st_r.timeoutFlagN)
      else $error("power-down or timeout flag wrong after sleep");
   wdt_clear_a: assert property (sleep_exec_s |=>
      wdtClear_r && wdtVal_r == 8'h00 ##1 !wdtClear_r)
      else $error("watchdog clear pulse wrong");
   osc_halt_a: assert property (
      sleep_exec_s ##1 !wakeSync_r[*3] |->
      !oscRun && $stable(q_r) && $stable(acc_r))
      else $error("core did not halt in sleep");
   rotl_result_a: assert property (!sleep_r && q_r == LSSRE_Q4 &&
      opCur == LSSRE_OP_ROTL |=> st_r.carry == $past(operand_r[7]) &&
      fileWrEn_r == $past(destFile) &&
      (fileWrEn_r ? fileData_r : acc_r) ==
      {$past(operand_r[6:0]), $past(st_r.carry)})
      else $error("rotate left result wrong");
   rotr_result_a: assert property (!sleep_r && q_r == LSSRE_Q4 &&
      opCur == LSSRE_OP_ROTR |=> st_r.carry == $past(operand_r[0]) &&
      fileWrEn_r == $past(destFile) &&
      (fileWrEn_r ? fileData_r : acc_r) ==
      {$past(st_r.carry), $past(operand_r[7:1])})
      else $error("rotate right result wrong");

endmodule
`default_nettype wire

// >>> lssre_exec_tb.sv
// self-checking bench for the literal-subtract / power-down / rotate block
// assumes the free-running Q1..Q4 timing and register map of the block
`timescale 1ns/1ps
`default_nettype none
module lssre_exec_tb;
   import lssre_pkg::*;
   typedef struct {
      int            due;
      logic [7:0]    w;
      lssre_status_t st;
      logic [15:0]   wr;
      logic          clr;
      logic          osc;
   } lssre_note_t;
   logic          clk = 1'b0, nrst = 1'b0, wakeRaw = 1'b0;
   logic          regWr = 1'b0, regRd = 1'b0, wdtClear, oscRun;
   logic [13:0]   instr = 14'h0000;
   logic [7:0]    fileRdData = 8'h00, regWrData = 8'h00, regRdData;
   logic [7:0]    accumulator, wdtLoadValue, w = 8'h00, k, a, f;
   logic [1:0]    regAddr = 2'h0;
   lssre_filewr_t fileWr;
   lssre_status_t status;
   lssre_status_t st = 5'b11000;
   lssre_qphase_t qPhase;
   logic          asleep = 1'b0;
   int            cyc = 0, failCount = 0, samplesChecked = 0, i;
   int            seed = 32'h7702;
   lssre_note_t   instQ[$], rdQ[$], n, m;

   lssre_exec lssre_exec_i (.clk, .nrst, .instr, .fileRdData, .wakeRaw,
      .regAddr, .regWrData, .regWr, .regRd, .regRdData, .fileWr, .status,
      .accumulator, .wdtClear, .wdtLoadValue, .oscRun, .qPhase);

   always #50 clk = ~clk;

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         failCount++;
         wrapUp;
      end
   end

   task check(input logic [15:0] seen, input logic [15:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         failCount++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task wrapUp;
      if (failCount == 0 && samplesChecked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // bounded wait for a quarter, seen where outputs are settled
   task sync(input lssre_qphase_t p);
      int j;
      for (j = 0; j < 12; j++) begin
         @(negedge clk);
         if (qPhase === p) break;
      end
      if (qPhase !== p) begin
         failCount++;
         wrapUp;
      end
   endtask

   function automatic logic [7:0] stb();
      return {2'b00, asleep, st};
   endfunction

   // register accesses keep clear of the Q4 result edge
   task wr(input logic [1:0] ad, input logic [7:0] d);
      sync(LSSRE_Q2);
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= ad;
      regWrData <= d;
      @(posedge clk);
      regWr <= 1'b0;
      if (ad == 2'h1) w = d;
      if (ad == 2'h0) st[2:0] = d[2:0];
   endtask

   task rd(input logic [1:0] ad, input logic [7:0] e);
      if (oscRun === 1'b1) sync(LSSRE_Q2);
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= ad;
      n.due = cyc + 2;
      n.w = e;
      rdQ.push_back(n);
      @(posedge clk);
      regRd <= 1'b0;
   endtask

   task exec(input logic [13:0] op, input logic [7:0] fd);
      logic [7:0] r;
      sync(LSSRE_Q4);
      @(posedge clk);
      instr <= op;
      fileRdData <= fd;
      n.due = cyc + 5;
      n.wr = 16'h0000;
      n.clr = 1'b0;
      n.osc = 1'b1;
      r = 8'h00;
      casez (op)
         14'b11_110?_????_????: begin
            r = op[7:0] - w;
            st.carry = op[7:0] >= w;
            st.halfBorrowFlag = op[3:0] >= w[3:0];
            st.zero = r == 8'h00;
            w = r;
         end
         14'b00_1101_????_????: begin
            r = {fd[6:0], st.carry};
            st.carry = fd[7];
         end
         14'b00_1100_????_????: begin
            r = {st.carry, fd[7:1]};
            st.carry = fd[0];
         end
         14'h0063: begin
            st.powerDownFlagN = 1'b0;
            st.timeoutFlagN = 1'b1;
            n.clr = 1'b1;
            n.osc = 1'b0;
            asleep = 1'b1;
         end
         default: ;
      endcase
      if (op[13:9] == 5'b00110 && op[7]) n.wr = {op[6:0], r, 1'b1};
      else if (op[13:9] == 5'b00110) w = r;
      n.w = w;
      n.st = st;
      instQ.push_back(n);
      // a no-op after the Q1 edge, so the word is not executed twice
      @(posedge clk);
      instr <= 14'h0000;
      // return at the result edge, so no later access lands mid-instruction
      repeat (3) @(posedge clk);
   endtask

   always @(negedge clk) begin
      if (instQ.size() > 0 && instQ[0].due == cyc) begin
         m = instQ.pop_front();
         check(accumulator, m.w);
         check(status, m.st);
         if (m.wr[0]) check(fileWr, m.wr);
         else check(fileWr.wrEn, 1'b0);
         check(wdtClear, m.clr);
         check(oscRun, m.osc);
         check(wdtLoadValue, 8'h00);
      end
      if (rdQ.size() > 0 && rdQ[0].due == cyc) begin
         m = rdQ.pop_front();
         check(regRdData, m.w);
      end
   end

   initial begin
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      rd(2'h0, stb());
      rd(2'h2, 8'h00);
      wr(2'h0, 8'hFF);
      rd(2'h0, stb());
      wr(2'h3, 8'h5A);
      rd(2'h3, 8'h00);
      wr(2'h2, 8'h77);
      rd(2'h2, 8'h00);
      // corner differences first, then random operands
      for (i = 0; i < 14; i++) begin
         k = (i < 3) ? 8'h02 : 8'($random(seed));
         a = (i < 3) ? 8'(i + 1) : 8'($random(seed));
         if (i == 3) a = k;
         wr(2'h1, a);
         exec({5'b11110, i[0], k}, 8'($random(seed)));
      end
      for (i = 0; i < 16; i++) begin
         f = (i < 4) ? 8'hE6 : 8'($random(seed));
         exec({5'b00110, i[0], i[1], 7'($random(seed))}, f);
      end
      exec(14'h0064, 8'h55);
      exec(14'h3800, 8'h55);
      exec(14'h0E80, 8'h55);
      exec(14'h0063, 8'h00);
      repeat (5) @(posedge clk);
      instr <= 14'h0000;
      rd(2'h0, stb());
      rd(2'h2, 8'h00);
      wakeRaw <= 1'b1;
      repeat (4) @(posedge clk);
      wakeRaw <= 1'b0;
      asleep = 1'b0;
      rd(2'h0, stb());
      wr(2'h1, 8'h10);
      exec(14'h3C0F, 8'h00);
      rd(2'h1, 8'hFF);
      repeat (8) @(posedge clk);
      wrapUp;
   end
endmodule
`default_nettype wire
